// ### csp_host_model.sv
// host serial master model for the control port
`timescale 1ns/1ps
module csp_host_model (
  output logic      sclk,      // serial clock, runs only in frames
  output logic      cs_n,      // select, active low
  output logic      sdio_i,    // data pin level seen by the port
  input  wire logic sdio_o,    // port drive value
  input  wire logic sdio_oe_n, // port drive enable, active low
  input  wire logic sdo_o,     // readback pin value
  input  wire logic sdo_oe_n   // readback pin enable, active low
);
  logic       lsb = 1'b0;
  logic       uni = 1'b0;
  logic       host_d = 1'b0;
  logic [7:0] wbuf [0:3];
  logic [7:0] rbuf [0:3];
  int         n_drv = 0;
  int         n_bad = 0;

  // a released pin toggles, so a stale value can never pass
  assign sdio_i = !sdio_oe_n ? sdio_o : host_d;

  initial begin
    sclk = 1'b0;
    cs_n <= 1'b1;
  end

  task automatic tick(input logic dr, input logic b, output logic rb);
    host_d = dr ? b : ~host_d;
    #7.5;
    rb = uni ? (!sdo_oe_n ? sdo_o : host_d) : sdio_i;
    if (uni ? !sdo_oe_n : !sdio_oe_n) n_drv++;
    if ((dr && !sdio_oe_n) || (uni ? !sdio_oe_n : !sdo_oe_n)) n_bad++;
    sclk = 1'b1;
    #7.5;
    sclk = 1'b0;
  endtask

  task automatic xfer(input logic rnw, input logic [1:0] len, input logic [12:0] adr,
                      input int nb, input int cut, input logic pause);
    logic [15:0] ins;
    logic        rb;
    int          i;
    int          k;
    ins = {rnw, len, adr};
    n_drv = 0;
    cs_n = 1'b0;
    #10;
    for (i = 0; i < 16 + 8 * nb && i != cut; i++) begin
      k = lsb ? i % 8 : 7 - i % 8;
      if (pause && i >= 16 && i % 8 == 0) begin
        cs_n = 1'b1;
        #40;
        cs_n = 1'b0;
        #10;
      end
      if (i < 16)
        tick(1'b1, ins[lsb ? i : 15 - i], rb);
      else begin
        tick(!rnw, wbuf[(i - 16) / 8][k], rb);
        rbuf[(i - 16) / 8][k] = rb;
      end
    end
    #5;
    cs_n = 1'b1;
    #30;
  endtask
endmodule

// ### csp_mem_if.sv
// carrier between the serial engine and the register store
`timescale 1ns/1ps
interface csp_mem_if;
  import csp_pkg::*;

  logic                  we;
  logic [CSP_ADDR_W-1:0] wr_addr;
  logic [7:0]            wr_data;
  logic                  update;
  logic                  soft_clr;
  logic [CSP_ADDR_W-1:0] rd_addr;
  logic                  rd_active;
  logic [7:0]            rd_data;

  modport engine (
    output we,
    output wr_addr,
    output wr_data,
    output update,
    output soft_clr,
    output rd_addr,
    output rd_active,
    input  rd_data
  );

  modport store (
    input  we,
    input  wr_addr,
    input  wr_data,
    input  update,
    input  soft_clr,
    input  rd_addr,
    input  rd_active,
    output rd_data
  );
endinterface

// ### csp_pkg.sv
// constants, encodings and types of the serial control port
// Functional notes
// [RULE1] each cycle opens with a 16-bit instruction on the first sixteen rising clocks
// [RULE2] instruction: top bit read/write, two length bits, thirteen address bits
// [RULE3] length 00/01/10 mean one/two/three bytes, 11 means streaming
// [RULE4] write data bits are sampled on the rising serial clock edge
// [RULE5] select may rise on byte boundaries of short transfers to pause, then resume
// [RULE6] select rising off a byte boundary abandons the transfer and resets the port
// [RULE7] streaming writes skip no address; bytes for blank locations have no effect
// [RULE8] writes land in a shadow buffer; update bit copies all to active, self-clears
// [RULE9] read shifts out N bytes from start address; streaming runs until select rises
// [RULE10] each readback bit is driven so it is valid at the falling edge
// [RULE11] readback on the shared data pin, or on the output pin in unidirectional mode
// [RULE12] a readback control bit picks shadow buffer or active registers as source
// [RULE13] only long instruction mode; its two config bits hold 11b from reset
// [RULE14] host sends top three address bits zero; map spans 0x000 to 0x232
// [RULE15] host writes config bytes with upper nibble mirroring the lower nibble
// [RULE16] default MSB first; LSB first select takes effect at once without update
// [RULE17] MSB first: bits high first, start names top byte, address decrements
// [RULE18] LSB first: bits low first, start names low byte, address increments
// [RULE19] streaming stops after 0x232; decrement wraps from 0x000 to 0x232 then stops
// [RULE20] a cycle starts only when the host pulls the active-low select low
// [RULE21] while select is high both serial data outputs are released
// [RULE22] bit and byte counters restart when select is newly asserted
package csp_pkg;

  localparam int          CSP_ADDR_W      = 10;
  localparam int          CSP_REG_COUNT   = 563;
  localparam int          CSP_SYNC_W      = 3;

  localparam logic [9:0]  CSP_ADDR_CFG    = 10'h000;
  localparam logic [9:0]  CSP_ADDR_RBSEL  = 10'h004;
  localparam logic [9:0]  CSP_ADDR_LAST   = 10'h232;
  localparam logic [9:0]  CSP_ADDR_ONE    = 10'h001;

  localparam logic [7:0]  CSP_CFG_RESET   = 8'h18;
  localparam logic [7:0]  CSP_CFG_LONG    = 8'h18;
  localparam logic [7:0]  CSP_REG_RESET   = 8'h00;
  localparam logic [6:0]  CSP_RBSEL_PAD   = 7'h00;

  localparam int          CSP_CFG_SDO_HI  = 7;
  localparam int          CSP_CFG_LSB_HI  = 6;
  localparam int          CSP_CFG_SOFT_HI = 5;
  localparam int          CSP_CFG_SOFT_LO = 2;
  localparam int          CSP_CFG_LSB_LO  = 1;
  localparam int          CSP_CFG_SDO_LO  = 0;
  localparam int          CSP_RBSEL_BIT   = 0;
  localparam int          CSP_UPD_BIT     = 0;

  localparam int          CSP_INS_RNW     = 15;
  localparam int          CSP_INS_LEN_HI  = 14;
  localparam int          CSP_INS_LEN_LO  = 13;
  localparam int          CSP_INS_ADR_HI  = 9;

  localparam logic [3:0]  CSP_INS_LAST    = 4'hF;
  localparam logic [3:0]  CSP_CNT_ZERO    = 4'h0;
  localparam logic [3:0]  CSP_CNT_ONE     = 4'h1;
  localparam logic [2:0]  CSP_BYTE_LAST   = 3'h7;
  localparam logic [2:0]  CSP_BIT_ZERO    = 3'h0;
  localparam logic [1:0]  CSP_LEFT_ONE    = 2'h1;
  localparam logic [1:0]  CSP_LEFT_NONE   = 2'h0;

  typedef enum logic [1:0] {
    CSP_LEN_ONE    = 2'b00,
    CSP_LEN_TWO    = 2'b01,
    CSP_LEN_THREE  = 2'b10,
    CSP_LEN_STREAM = 2'b11
  } csp_len_t;

  typedef enum logic [1:0] {
    CSP_PH_INSTR = 2'b00,
    CSP_PH_DATA  = 2'b01,
    CSP_PH_DONE  = 2'b10
  } csp_phase_t;

endpackage

// ### csp_regmem.sv
// shadow buffer and active register arrays with registered readback
`timescale 1ns/1ps
module csp_regmem (
  input  wire logic sclk, // serial clock
  input  wire logic rst,  // async reset, active high
  csp_mem_if.store  m     // engine side
);
  import csp_pkg::*;

  logic [7:0] shadow_r [CSP_REG_COUNT];
  logic [7:0] active_r [CSP_REG_COUNT];
  logic [7:0] rd_data_r;
  logic       rd_in_map;

  generate
    for (genvar i = 0; i < CSP_REG_COUNT; i++) begin : g_ent
      localparam logic [CSP_ADDR_W-1:0] IDX = CSP_ADDR_W'(i);
      wire hit = m.we && (m.wr_addr == IDX);
      // copy uses the old shadow word, so all entries switch on one edge
      always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
          shadow_r[i] <= CSP_REG_RESET;
          active_r[i] <= CSP_REG_RESET;
        end else if (m.soft_clr) begin
          shadow_r[i] <= CSP_REG_RESET;
          active_r[i] <= CSP_REG_RESET;
        end else begin
          if (hit)
            shadow_r[i] <= m.wr_data;     // [RULE8]
          if (m.update)
            active_r[i] <= shadow_r[i];   // [RULE8]
        end
      end
    end
  endgenerate

  assign rd_in_map = (m.rd_addr <= CSP_ADDR_LAST);

  always_ff @(posedge sclk or posedge rst) begin
    if (rst)
      rd_data_r <= CSP_REG_RESET;
    else if (!rd_in_map)
      rd_data_r <= CSP_REG_RESET;
    else if (m.rd_active)
      rd_data_r <= active_r[m.rd_addr];   // [RULE12]
    else
      rd_data_r <= shadow_r[m.rd_addr];   // [RULE12]
  end

  assign m.rd_data = rd_data_r;
endmodule

// ### csp_sync.sv
// two-stage level synchroniser into the core clock
`timescale 1ns/1ps
module csp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock, // core clock
  input  wire logic             rst,   // async reset, active high
  input  wire logic [WIDTH-1:0] d,     // levels from another domain
  output logic      [WIDTH-1:0] q      // synchronised levels
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  // meta_r feeds only q_r
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;
endmodule

// ### csp_top.sv
// serial control port: instruction decode, byte transfer, config and readback
`timescale 1ns/1ps
module csp_top (
  input  wire logic clock,          // core clock, 25 MHz
  input  wire logic rst,            // async reset, active high
  input  wire logic sclk,           // serial clock from host
  input  wire logic cs_n,           // select from host, active low
  input  wire logic sdio_i,         // data pin, input side
  output logic      sdio_o,         // data pin, output side
  output logic      sdio_oe_n,      // data pin drive enable, active low
  output logic      sdo_o,          // separate readback pin
  output logic      sdo_oe_n,       // readback pin drive enable, active low
  output logic      frame_active,   // select low, seen in core domain
  output logic      update_pulse,   // one core cycle per update command
  output logic      soft_reset_out  // soft reset level in core domain
);
  import csp_pkg::*;

  csp_mem_if mem ();

  csp_phase_t            phase_r;
  csp_phase_t            phase_nxt;
  csp_phase_t            base_phase;
  logic [3:0]            bit_cnt_r;
  logic [3:0]            bit_cnt_nxt;
  logic [3:0]            base_cnt;
  logic [15:0]           sr_r;
  logic [15:0]           sr_nxt;
  logic                  rnw_r;
  logic                  rnw_nxt;
  logic                  stream_r;
  logic                  stream_nxt;
  logic [1:0]            left_r;
  logic [1:0]            left_nxt;
  logic [CSP_ADDR_W-1:0] addr_r;
  logic [CSP_ADDR_W-1:0] addr_nxt;
  logic [7:0]            cfg_r;
  logic [7:0]            cfg_nxt;
  logic                  rbsel_r;
  logic                  rbsel_nxt;
  logic                  restart_tgl_r;
  logic                  seen_tgl_r;
  logic                  upd_tgl_r;
  logic                  sdio_o_r;
  logic                  sdio_oe_n_r;
  logic                  sdo_o_r;
  logic                  sdo_oe_n_r;
  logic                  frame_active_r;
  logic                  upd_seen_r;
  logic                  update_pulse_r;
  logic                  soft_reset_r;
  logic [CSP_SYNC_W-1:0] sync_d;
  logic [CSP_SYNC_W-1:0] sync_q;

  // config decoding; mirrored pairs are ored so either bit order works, except soft_reset_out, which takes only the upper soft reset bit
  wire lsb_first = cfg_r[CSP_CFG_LSB_HI] | cfg_r[CSP_CFG_LSB_LO];     // [RULE16]
  wire sdo_mode  = cfg_r[CSP_CFG_SDO_HI] | cfg_r[CSP_CFG_SDO_LO];     // [RULE11]
  wire soft_rst  = cfg_r[CSP_CFG_SOFT_HI] | cfg_r[CSP_CFG_SOFT_LO];

  // a restart seen at the select edge is picked up on the next rising clock
  wire fresh      = restart_tgl_r != seen_tgl_r;                      // [RULE22]
  assign base_phase = fresh ? CSP_PH_INSTR : phase_r;                 // [RULE22]
  assign base_cnt   = fresh ? CSP_CNT_ZERO : bit_cnt_r;               // [RULE22]

  // shift direction follows bit order
  assign sr_nxt = lsb_first ? {sdio_i, sr_r[15:1]}                    // [RULE18]
                            : {sr_r[14:0], sdio_i};                   // [RULE17]

  wire instr_end = (base_phase == CSP_PH_INSTR) && (base_cnt == CSP_INS_LAST); // [RULE1]
  wire byte_end  = (base_phase == CSP_PH_DATA) && (base_cnt[2:0] == CSP_BYTE_LAST);
  wire [7:0] data_byte = lsb_first ? sr_nxt[15:8] : sr_nxt[7:0];
  wire [1:0] len_field = sr_nxt[CSP_INS_LEN_HI:CSP_INS_LEN_LO];       // [RULE2]

  // stream ends once the last address has been accessed
  wire last_byte = stream_r ? (addr_r == CSP_ADDR_LAST)               // [RULE19]
                            : (left_r == CSP_LEFT_NONE);              // [RULE3]

  wire [CSP_ADDR_W-1:0] addr_inc = addr_r + CSP_ADDR_ONE;
  wire [CSP_ADDR_W-1:0] addr_dec = (addr_r == CSP_ADDR_CFG) ? CSP_ADDR_LAST      // [RULE19]
                                                            : addr_r - CSP_ADDR_ONE;
  wire [CSP_ADDR_W-1:0] addr_step = lsb_first ? addr_inc              // [RULE18]
                                              : addr_dec;             // [RULE17]

  // write decode; special locations live here, not in the store
  wire wr_hit   = byte_end && !rnw_r;                                 // [RULE4]
  wire cfg_wr   = wr_hit && (addr_r == CSP_ADDR_CFG);
  wire rbsel_wr = wr_hit && (addr_r == CSP_ADDR_RBSEL);
  wire upd_wr   = wr_hit && (addr_r == CSP_ADDR_LAST) && data_byte[CSP_UPD_BIT]; // [RULE8]
  wire store_wr = wr_hit && (addr_r < CSP_ADDR_LAST)                  // [RULE7]
                         && (addr_r != CSP_ADDR_CFG)
                         && (addr_r != CSP_ADDR_RBSEL);

  // long-instruction bits cannot be cleared
  assign cfg_nxt   = cfg_wr ? (data_byte | CSP_CFG_LONG) : cfg_r;     // [RULE13] [RULE16]
  assign rbsel_nxt = soft_rst ? 1'b0
                   : rbsel_wr ? data_byte[CSP_RBSEL_BIT] : rbsel_r;   // [RULE12]

  always_comb begin
    phase_nxt   = base_phase;
    bit_cnt_nxt = base_cnt + CSP_CNT_ONE;
    rnw_nxt     = rnw_r;
    stream_nxt  = stream_r;
    left_nxt    = left_r;
    addr_nxt    = addr_r;
    case (base_phase)
      CSP_PH_INSTR: begin
        if (instr_end) begin                                          // [RULE1]
          phase_nxt   = CSP_PH_DATA;
          bit_cnt_nxt = CSP_CNT_ZERO;
          rnw_nxt     = sr_nxt[CSP_INS_RNW];                          // [RULE2]
          stream_nxt  = (len_field == CSP_LEN_STREAM);                // [RULE3]
          left_nxt    = len_field;                                    // [RULE3]
          // top three address bits are ignored; host keeps them zero
          addr_nxt    = sr_nxt[CSP_INS_ADR_HI:0];                     // [RULE14]
        end
      end
      CSP_PH_DATA: begin
        if (byte_end) begin
          bit_cnt_nxt = CSP_CNT_ZERO;
          if (last_byte) begin
            phase_nxt = CSP_PH_DONE;                                  // [RULE9] [RULE19]
          end else begin
            addr_nxt  = addr_step;                                    // [RULE17] [RULE18]
            left_nxt  = left_r - CSP_LEFT_ONE;
          end
        end
      end
      CSP_PH_DONE: begin
        // extra clocks after the last byte are ignored
        bit_cnt_nxt = base_cnt;
      end
      default: begin
        phase_nxt   = CSP_PH_INSTR;
        bit_cnt_nxt = CSP_CNT_ZERO;
      end
    endcase
  end

  // select and data are synchronous to the serial clock by protocol
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      phase_r    <= CSP_PH_INSTR;
      bit_cnt_r  <= CSP_CNT_ZERO;
      sr_r       <= '0;
      rnw_r      <= 1'b0;
      stream_r   <= 1'b0;
      left_r     <= CSP_LEFT_NONE;
      addr_r     <= CSP_ADDR_CFG;
      cfg_r      <= CSP_CFG_RESET;                                    // [RULE13] [RULE16]
      rbsel_r    <= 1'b0;
      seen_tgl_r <= 1'b0;
      upd_tgl_r  <= 1'b0;
    end else if (!cs_n) begin                                         // [RULE20]
      phase_r    <= phase_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      sr_r       <= sr_nxt;                                           // [RULE4]
      rnw_r      <= rnw_nxt;
      stream_r   <= stream_nxt;
      left_r     <= left_nxt;
      addr_r     <= addr_nxt;
      cfg_r      <= cfg_nxt;
      rbsel_r    <= rbsel_nxt;
      seen_tgl_r <= restart_tgl_r;
      upd_tgl_r  <= upd_tgl_r ^ upd_wr;
    end
  end

  // decide at the select's rising edge whether the next cycle starts over;
  // only a pause on a byte boundary of the instruction or of a short transfer's data keeps the state
  wire restart_cond = (bit_cnt_r[2:0] != CSP_BIT_ZERO)                // [RULE6]
                   || (phase_r == CSP_PH_DONE)                        // [RULE5]
                   || ((phase_r == CSP_PH_DATA) && stream_r);         // [RULE9]

  always_ff @(posedge cs_n or posedge rst) begin
    if (rst)
      restart_tgl_r <= 1'b0;
    else if (!fresh && restart_cond)                                  // [RULE5] [RULE6]
      restart_tgl_r <= ~restart_tgl_r;
  end

  assign mem.we        = store_wr;                                    // [RULE8]
  assign mem.wr_addr   = addr_r;
  assign mem.wr_data   = data_byte;
  assign mem.update    = upd_wr;                                      // [RULE8]
  assign mem.soft_clr  = soft_rst;
  assign mem.rd_addr   = addr_nxt;
  assign mem.rd_active = rbsel_r;                                     // [RULE12]

  csp_regmem u_mem (
    .sclk (sclk),
    .rst  (rst),
    .m    (mem)
  );

  // readback byte; update location always reads zero, being self-clearing
  wire is_cfg   = addr_r == CSP_ADDR_CFG;
  wire is_rbsel = addr_r == CSP_ADDR_RBSEL;
  wire is_upd   = addr_r == CSP_ADDR_LAST;
  wire [7:0] rd_byte = is_cfg   ? cfg_r
                     : is_rbsel ? {CSP_RBSEL_PAD, rbsel_r}
                     : is_upd   ? CSP_REG_RESET
                     : mem.rd_data;                                   // [RULE9]
  wire [2:0] out_idx = lsb_first ? bit_cnt_r[2:0]                     // [RULE18]
                                 : CSP_BYTE_LAST - bit_cnt_r[2:0];    // [RULE17]
  wire       out_bit = rd_byte[out_idx];
  wire       drive   = (phase_r == CSP_PH_DATA) && rnw_r && !fresh;   // [RULE9]

  // outputs change on the falling edge; select high releases them at once.
  // limitation: after a pause the first resumed read bit is never driven; the pin stays released until the next falling edge
  wire oe_kill = rst | cs_n;

  always_ff @(negedge sclk or posedge oe_kill) begin
    if (oe_kill) begin
      sdio_o_r    <= 1'b0;
      sdio_oe_n_r <= 1'b1;                                            // [RULE21]
      sdo_o_r     <= 1'b0;
      sdo_oe_n_r  <= 1'b1;                                            // [RULE21]
    end else begin
      sdio_o_r    <= out_bit;                                         // [RULE10]
      sdio_oe_n_r <= !(drive && !sdo_mode);                           // [RULE11]
      sdo_o_r     <= out_bit;                                         // [RULE10]
      sdo_oe_n_r  <= !(drive && sdo_mode);                            // [RULE11]
    end
  end

  // core clock side: select level, update events, soft reset level
  // select goes in inverted so the synchroniser's reset level is the idle level
  assign sync_d = {cfg_r[CSP_CFG_SOFT_HI], upd_tgl_r, !cs_n};

  csp_sync #(
    .WIDTH (CSP_SYNC_W)
  ) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     (sync_d),
    .q     (sync_q)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frame_active_r <= 1'b0;
      upd_seen_r     <= 1'b0;
      update_pulse_r <= 1'b0;
      soft_reset_r   <= 1'b0;
    end else begin
      frame_active_r <= sync_q[0];
      upd_seen_r     <= sync_q[1];
      update_pulse_r <= sync_q[1] ^ upd_seen_r;
      soft_reset_r   <= sync_q[2];
    end
  end

  assign sdio_o         = sdio_o_r;
  assign sdio_oe_n      = sdio_oe_n_r;
  assign sdo_o          = sdo_o_r;
  assign sdo_oe_n       = sdo_oe_n_r;
  assign frame_active   = frame_active_r;
  assign update_pulse   = update_pulse_r;
  assign soft_reset_out = soft_reset_r;
endmodule

// ### csp_top_bench.sv
// self-checking bench for the serial control port
`timescale 1ns/1ps
module csp_top_bench;
  import csp_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b0;
  logic sclk, cs_n, sdio_i, sdio_o, sdio_oe_n, sdo_o, sdo_oe_n;
  logic frame_active, update_pulse, soft_reset_out;
  int   err_total = 0;
  int   n_checks = 0;
  int   n_upd = 0;

  csp_top i_dut (.clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i),
    .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n),
    .frame_active(frame_active), .update_pulse(update_pulse),
    .soft_reset_out(soft_reset_out));
  csp_host_model i_host (.sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o),
    .sdio_oe_n(sdio_oe_n), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n));

  initial begin
    forever #20 clock = ~clock;
  end

  always @(posedge clock) begin
    if (update_pulse === 1'b1) n_upd++;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [1:0] len, input int nb,
                    input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    i_host.wbuf[0] = b0;
    i_host.wbuf[1] = b1;
    i_host.wbuf[2] = b2;
    @(posedge clock);
    #1;
    i_host.xfer(1'b0, len, a, nb, -1, 1'b0);
  endtask

  task automatic rd(input logic [12:0] a, input logic [1:0] len, input int nb);
    @(posedge clock);
    #1;
    i_host.xfer(1'b1, len, a, nb, -1, 1'b0);
  endtask

  task automatic t_defaults;
    rd(13'h0000, 2'b00, 1);
    chk("cfg", CSP_CFG_RESET, i_host.rbuf[0]);
    chk("drv bits", 8'h08, i_host.n_drv[7:0]);
    rd(13'h0004, 2'b00, 1);
    chk("rbsel", 8'h00, i_host.rbuf[0]);
    chk("idle oe", 8'h01, {7'h00, sdio_oe_n & sdo_oe_n});
    chk("soft", 8'h00, {7'h00, soft_reset_out});
    $display("t_defaults done");
  endtask

  task automatic t_shadow;
    int u;
    wr(13'h0012, 2'b10, 3, 8'hA5, 8'h3C, 8'h96);
    rd(13'h0012, 2'b10, 3);
    chk("shadow0", 8'hA5, i_host.rbuf[0]);
    chk("shadow2", 8'h96, i_host.rbuf[2]);
    wr(13'h0004, 2'b00, 1, 8'h01, 8'h00, 8'h00);
    rd(13'h0011, 2'b00, 1);
    chk("stale", 8'h00, i_host.rbuf[0]);
    u = n_upd;
    wr(13'h0232, 2'b00, 1, 8'h01, 8'h00, 8'h00);
    repeat (10) @(posedge clock);
    chk("upd count", 8'h01, 8'(n_upd - u));
    rd(13'h0012, 2'b10, 3);
    chk("active1", 8'h3C, i_host.rbuf[1]);
    rd(13'h0232, 2'b00, 1);
    chk("upd bit", 8'h00, i_host.rbuf[0]);
    wr(13'h0004, 2'b00, 1, 8'h00, 8'h00, 8'h00);
    $display("t_shadow done");
  endtask

  task automatic t_pause_abort;
    i_host.wbuf[0] = 8'h11;
    i_host.wbuf[1] = 8'h22;
    i_host.xfer(1'b0, 2'b01, 13'h0020, 2, -1, 1'b1);
    rd(13'h0020, 2'b01, 2);
    chk("paused lo", 8'h22, i_host.rbuf[1]);
    i_host.wbuf[0] = 8'hFF;
    i_host.xfer(1'b0, 2'b00, 13'h0030, 1, 5, 1'b0);
    i_host.xfer(1'b0, 2'b00, 13'h0030, 1, 20, 1'b0);
    rd(13'h0030, 2'b00, 1);
    chk("aborted", 8'h00, i_host.rbuf[0]);
    rd(13'h0020, 2'b00, 1);
    chk("after abort", 8'h11, i_host.rbuf[0]);
    $display("t_pause_abort done");
  endtask

  task automatic t_stream;
    wr(13'h0001, 2'b00, 1, 8'h5A, 8'h00, 8'h00);
    rd(13'h0001, 2'b11, 4);
    chk("blank", 8'h5A, i_host.rbuf[0]);
    chk("wrap cfg", 8'h18, i_host.rbuf[1]);
    chk("last", 8'h00, i_host.rbuf[2]);
    chk("stop bits", 8'h18, i_host.n_drv[7:0]);
    $display("t_stream done");
  endtask

  task automatic t_lsb;
    wr(13'h0000, 2'b00, 1, 8'h5A, 8'h00, 8'h00);
    i_host.lsb = 1'b1;
    rd(13'h0000, 2'b00, 1);
    chk("lsb cfg", 8'h5A, i_host.rbuf[0]);
    i_host.wbuf[3] = 8'hEE;
    wr(13'h0230, 2'b11, 4, 8'h77, 8'h88, 8'h00);
    rd(13'h0230, 2'b11, 4);
    chk("inc0", 8'h77, i_host.rbuf[0]);
    chk("inc1", 8'h88, i_host.rbuf[1]);
    chk("inc stop", 8'h18, i_host.n_drv[7:0]);
    wr(13'h0000, 2'b00, 1, 8'h18, 8'h00, 8'h00);
    i_host.lsb = 1'b0;
    rd(13'h0000, 2'b00, 1);
    chk("msb back", 8'h18, i_host.rbuf[0]);
    $display("t_lsb done");
  endtask

  task automatic t_uni;
    wr(13'h0000, 2'b00, 1, 8'h99, 8'h00, 8'h00);
    i_host.uni = 1'b1;
    rd(13'h0012, 2'b00, 1);
    chk("sdo data", 8'hA5, i_host.rbuf[0]);
    chk("sdo bits", 8'h08, i_host.n_drv[7:0]);
    wr(13'h0000, 2'b00, 1, 8'h18, 8'h00, 8'h00);
    i_host.uni = 1'b0;
    wr(13'h0000, 2'b00, 1, 8'h3C, 8'h00, 8'h00);
    repeat (5) @(posedge clock);
    chk("soft on", 8'h01, {7'h00, soft_reset_out});
    wr(13'h0000, 2'b00, 1, 8'h18, 8'h00, 8'h00);
    rd(13'h0012, 2'b00, 1);
    chk("soft clr", 8'h00, i_host.rbuf[0]);
    chk("clashes", 8'h00, i_host.n_bad[7:0]);
    $display("t_uni done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    give_verdict();
  end

  initial begin
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    t_defaults();
    t_shadow();
    t_pause_abort();
    t_stream();
    t_lsb();
    t_uni();
    give_verdict();
  end
endmodule

// ### csp_top_sva.sv
// concurrent checks on the serial control port pins
`timescale 1ns/1ps
module csp_top_sva (
  input wire logic clock,          // core clock
  input wire logic rst,            // async reset, active high
  input wire logic sclk,           // serial clock
  input wire logic cs_n,           // select, active low
  input wire logic sdio_i,         // data pin input side
  input wire logic sdio_o,         // data pin output side
  input wire logic sdio_oe_n,      // data pin enable, active low
  input wire logic sdo_o,          // readback pin
  input wire logic sdo_oe_n,       // readback pin enable, active low
  input wire logic frame_active,   // select seen in core domain
  input wire logic update_pulse,   // update strobe
  input wire logic soft_reset_out  // soft reset level
);
  logic [7:0] edges_r;
  logic [3:0] since_r;
  logic       drv;

  assign drv = !(sdio_oe_n && sdo_oe_n);

  // rising edges since select fell; a pause restarts it, so resumed reads trip the instruction-phase checks
  always_ff @(posedge sclk or posedge cs_n or posedge rst) begin
    if (rst)
      edges_r <= 8'h00;
    else if (cs_n)
      edges_r <= 8'h00;
    else if (edges_r != 8'hFF)
      edges_r <= edges_r + 8'h01;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      since_r <= 4'hF;
    else if (frame_active)
      since_r <= 4'h0;
    else if (since_r != 4'hF)
      since_r <= since_r + 4'h1;
  end

  property hold_byte_p;
    @(posedge sclk) disable iff (rst || cs_n)
      (drv && edges_r[2:0] != 3'h7) |=> drv;
  endproperty

  idle_release_a: assert property (@(posedge clock) disable iff (rst)
    cs_n |-> sdio_oe_n && sdo_oe_n) else $error("pin driven while deselected");
  one_pin_a: assert property (@(posedge clock) disable iff (rst)
    !(!sdio_oe_n && !sdo_oe_n)) else $error("both data pins driven");
  upd_single_a: assert property (@(posedge clock) disable iff (rst)
    update_pulse |=> !update_pulse) else $error("update strobe too long");
  frame_track_a: assert property (@(posedge clock) disable iff (rst)
    frame_active == !$past(cs_n, 3)) else $error("frame flag out of step");
  upd_quiet_a: assert property (@(posedge clock) disable iff (rst)
    update_pulse |-> since_r < 4'h8) else $error("update strobe outside a frame");
  instr_quiet_a: assert property (@(negedge sclk) disable iff (rst)
    edges_r < 8'h10 |-> sdio_oe_n && sdo_oe_n) else $error("drive during instruction");
  early_drive_a: assert property (@(posedge sclk) disable iff (rst)
    drv |-> edges_r >= 8'h10) else $error("readback before data phase");
  hold_byte_a: assert property (hold_byte_p)
    else $error("readback dropped inside a byte");

  cover property (@(posedge clock) update_pulse);
  cover property (@(posedge clock) !sdo_oe_n);
  cover property (@(posedge sclk) edges_r == 8'h28);
endmodule

bind csp_top csp_top_sva i_sva (.clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n),
  .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n), .sdo_o(sdo_o),
  .sdo_oe_n(sdo_oe_n), .frame_active(frame_active), .update_pulse(update_pulse),
  .soft_reset_out(soft_reset_out));
